// >>> verilog/lrmfc_pkg.sv
// constants and types shared by the lane route, marker and fifo config registers
package lrmfc_pkg;

	// ==========================================================
	// register addresses on the management port
	localparam logic [4:0] LRMFC_ADDR_MARKER  = 5'h18; // receive_marker_control
	localparam logic [4:0] LRMFC_ADDR_FIFO    = 5'h19; // transmit_fifo_align_control
	localparam logic [4:0] LRMFC_ADDR_ROUTE   = 5'h1b; // lane_source_routing

	// ==========================================================
	// sizes
	localparam int         LRMFC_LANES        = 4;     // lanes with own routing copy

	// ==========================================================
	// values after reset
	localparam logic [15:0] LRMFC_RST_MARKER  = 16'h0cc8;
	localparam logic [15:0] LRMFC_RST_FIFO    = 16'h02bc;
	localparam logic [15:0] LRMFC_RST_ROUTE [0:LRMFC_LANES-1] =
		'{16'h3020, 16'h3121, 16'h3222, 16'h3323};
	localparam logic [15:0] LRMFC_RD_UNMAPPED = 16'h0000; // answer to other addresses

	// ==========================================================
	// field positions, receive_marker_control
	localparam int MRK_SEL_LSB    = 12; // receive marker select, 3 bits
	localparam int MRK_DET_BIT    = 11; // marker detection enable

	// field positions, transmit_fifo_align_control
	localparam int FIFO_DEPTH_LSB = 13; // slow tx buffer depth, 3 bits
	localparam int FIFO_LVL_LSB   = 11; // slow tx buffer watermark, 2 bits
	localparam int SYNC_ON_BIT    = 10; // custom sync code enable
	localparam int SYNC_CODE_LSB  = 0;  // custom sync code, 10 bits

	// field positions, lane_source_routing
	localparam int RX_DIV_LSB     = 14; // rx rate divider, 2 bits
	localparam int RX_TC_BIT      = 13; // rx tolerance comp enable
	localparam int RX_SRC_LSB     = 11; // rx source pick, 2 bits
	localparam int RX_IDX_LSB     = 8;  // rx lane index, 3 bits, top ignored
	localparam int TX_DIV_LSB     = 6;  // tx rate divider, 2 bits
	localparam int TX_TC_BIT      = 5;  // tx tolerance comp enable
	localparam int TX_SRC_LSB     = 3;  // tx source pick, 2 bits
	localparam int TX_IDX_LSB     = 0;  // tx lane index, 3 bits, top ignored

	// ==========================================================
	// types
	typedef logic [15:0] lrmfc_word_t;  // one management register word

endpackage

// >>> verilog/lrmfc_config_regs.sv
// configuration registers for marker detect, slow tx fifo and lane routing
//
// Contract
// RULE1: rx marker select in bits 14:12, reset zero
// RULE2: detect enable gated by bitwise mux mode
// RULE3: tx buffer depth bits 15:13, reset zero
// RULE4: tx buffer watermark bits 12:11, reset zero
// RULE5: bit 10 selects custom sync code
// RULE6: ten bit sync code, reset 2bc
// RULE7: route write touches only masked lanes
// RULE8: rx rate divider bits 15:14 per lane
// RULE9: bit 13 rx tolerance comp enable
// RULE10: bits 12:11 pick rx output source
// RULE11: bits 10:8 pick rx lane, top ignored
// RULE12: tx rate divider bits 7:6 per lane
// RULE13: bit 5 tx tolerance comp enable
// RULE14: bits 4:3 pick tx output source
// RULE15: bits 2:0 pick tx lane, top ignored
// RULE16: four lane copies with own resets
// RULE17: marker and fifo reset words kept
// RULE18: fields read back last written value
`timescale 1ns/100ps

module lrmfc_config_regs
	import lrmfc_pkg::*;
(
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	// management register port
	input  wire logic [4:0]                    regAddr,
	input  wire logic [15:0]                   regWrData,
	input  wire logic                          regWrEn,
	input  wire logic                          regRdEn,
	output logic      [15:0]                   regRdData,
	output logic                               regRdValid,
	// lane selection mask and mode from elsewhere
	input  wire logic [LRMFC_LANES-1:0]        laneWriteMask,
	input  wire logic                          rxBitwiseMuxMode,
	// marker settings
	output logic      [2:0]                    rxMarkerSelect,
	output logic                               markerDetectOn,
	output logic                               markerDetectActive,
	// slow tx buffer and sync code settings
	output logic      [2:0]                    slowTxBufferDepth,
	output logic      [1:0]                    slowTxBufferLevel,
	output logic                               customSyncCodeOn,
	output logic      [9:0]                    customSyncCode,
	// per lane routing settings
	output logic      [LRMFC_LANES-1:0][1:0]   rxLaneRateDivider,
	output logic      [LRMFC_LANES-1:0]        rxLaneToleranceCompOn,
	output logic      [LRMFC_LANES-1:0][1:0]   rxLaneSourcePick,
	output logic      [LRMFC_LANES-1:0][1:0]   rxLaneIndexPick,
	output logic      [LRMFC_LANES-1:0][1:0]   txLaneRateDivider,
	output logic      [LRMFC_LANES-1:0]        txLaneToleranceCompOn,
	output logic      [LRMFC_LANES-1:0][1:0]   txLaneSourcePick,
	output logic      [LRMFC_LANES-1:0][1:0]   txLaneIndexPick
);

	// ==========================================================
	// storage
	lrmfc_word_t                   markerReg;      // receive_marker_control
	lrmfc_word_t                   fifoReg;        // transmit_fifo_align_control
	lrmfc_word_t                   routeReg [0:LRMFC_LANES-1]; // lane_source_routing copies
	logic                          detectActReg;   // gated marker detect
	lrmfc_word_t                   rdDataReg;      // read answer word
	logic                          rdValidReg;     // read answer strobe

	// ==========================================================
	// address decode
	wire logic         hitMarker = (regAddr == LRMFC_ADDR_MARKER);
	wire logic         hitFifo   = (regAddr == LRMFC_ADDR_FIFO);
	wire logic         hitRoute  = (regAddr == LRMFC_ADDR_ROUTE);
	wire logic         wrMarker  = regWrEn & hitMarker;
	wire logic         wrFifo    = regWrEn & hitFifo;
	wire logic         wrRoute   = regWrEn & hitRoute;

	// ==========================================================
	// read lane pick: lowest masked lane, lane 0 when mask empty
	wire logic [1:0]   rdLane    = laneWriteMask[0] ? 2'h0 :
	                               laneWriteMask[1] ? 2'h1 :
	                               laneWriteMask[2] ? 2'h2 :
	                               laneWriteMask[3] ? 2'h3 : 2'h0;

	// read mux, unmapped addresses answer zero
	wire lrmfc_word_t  rdData_next = hitMarker ? markerReg :
	                                 hitFifo   ? fifoReg   :
	                                 hitRoute  ? routeReg[rdLane] :
	                                 LRMFC_RD_UNMAPPED;

	// ==========================================================
	// marker control register, reserved bits kept as written
	// RULE1: marker select stored
	// RULE17: marker reset word
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			markerReg <= LRMFC_RST_MARKER;
		end else if (wrMarker) begin
			markerReg <= regWrData;
		end
	end

	// detect enable acts only in bitwise mux mode
	// RULE2: mode gates detection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			detectActReg <= 1'b0;
		end else begin
			detectActReg <= markerReg[MRK_DET_BIT] & rxBitwiseMuxMode;
		end
	end

	// ==========================================================
	// fifo and sync code register
	// RULE3: depth field stored
	// RULE4: watermark field stored
	// RULE5: sync code enable stored
	// RULE6: sync code stored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fifoReg <= LRMFC_RST_FIFO;
		end else if (wrFifo) begin
			fifoReg <= regWrData;
		end
	end

	// ==========================================================
	// per lane routing copies
	genvar ln;
	generate
		for (ln = 0; ln < LRMFC_LANES; ln++) begin : g_lane
			// RULE7: masked write only
			// RULE16: own reset per lane
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					routeReg[ln] <= LRMFC_RST_ROUTE[ln];
				end else if (wrRoute && laneWriteMask[ln]) begin
					routeReg[ln] <= regWrData;
				end
			end

			// field views of each lane word
			// RULE8: rx rate divider
			assign rxLaneRateDivider[ln]     = routeReg[ln][RX_DIV_LSB+:2];
			// RULE9: rx tolerance comp
			assign rxLaneToleranceCompOn[ln] = routeReg[ln][RX_TC_BIT];
			// RULE10: rx source pick
			assign rxLaneSourcePick[ln]      = routeReg[ln][RX_SRC_LSB+:2];
			// RULE11: rx lane, top bit ignored
			assign rxLaneIndexPick[ln]       = routeReg[ln][RX_IDX_LSB+:2];
			// RULE12: tx rate divider
			assign txLaneRateDivider[ln]     = routeReg[ln][TX_DIV_LSB+:2];
			// RULE13: tx tolerance comp
			assign txLaneToleranceCompOn[ln] = routeReg[ln][TX_TC_BIT];
			// RULE14: tx source pick
			assign txLaneSourcePick[ln]      = routeReg[ln][TX_SRC_LSB+:2];
			// RULE15: tx lane, top bit ignored
			assign txLaneIndexPick[ln]       = routeReg[ln][TX_IDX_LSB+:2];
		end
	endgenerate

	// ==========================================================
	// read answer, one cycle after the request
	// RULE18: readback of stored words
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdDataReg  <= LRMFC_RD_UNMAPPED;
			rdValidReg <= 1'b0;
		end else begin
			rdValidReg <= regRdEn;
			if (regRdEn) begin
				rdDataReg <= rdData_next;
			end
		end
	end

	// ==========================================================
	// outputs straight from storage
	assign regRdData          = rdDataReg;
	assign regRdValid         = rdValidReg;
	assign rxMarkerSelect     = markerReg[MRK_SEL_LSB+:3];
	assign markerDetectOn     = markerReg[MRK_DET_BIT];
	assign markerDetectActive = detectActReg;
	assign slowTxBufferDepth  = fifoReg[FIFO_DEPTH_LSB+:3];
	assign slowTxBufferLevel  = fifoReg[FIFO_LVL_LSB+:2];
	assign customSyncCodeOn   = fifoReg[SYNC_ON_BIT];
	assign customSyncCode     = fifoReg[SYNC_CODE_LSB+:10];

	// ==========================================================
	// checks

	// write to an address, then a read of it in the next cycle
	sequence s_wr_route_then_rd;
		wrRoute && (laneWriteMask == 4'h1) ##1 (regRdEn && hitRoute && laneWriteMask == 4'h1);
	endsequence

	// marker word after reset
	a_marker_reset: assert property (@(posedge clk) // RULE1
		$past(sys_rst) |-> markerReg == 16'h0cc8 && rxMarkerSelect == 3'h0)
		else $error("marker register wrong after reset");

	// detect active only with mode and enable, cycles right after reset skipped
	a_detect_gate: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
		!$past(sys_rst) |->
			markerDetectActive == ($past(rxBitwiseMuxMode) && $past(markerDetectOn)))
		else $error("marker detect gating wrong");

	// fifo word after reset
	a_fifo_reset: assert property (@(posedge clk) // RULE6
		$past(sys_rst) |-> slowTxBufferDepth == 3'h0 && slowTxBufferLevel == 2'h0
			&& !customSyncCodeOn && customSyncCode == 10'h2bc)
		else $error("fifo register wrong after reset");

	// fifo fields take written value
	a_fifo_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
		wrFifo |=> slowTxBufferDepth == $past(regWrData[15:13])
			&& slowTxBufferLevel == $past(regWrData[12:11])
			&& customSyncCodeOn == $past(regWrData[10]))
		else $error("fifo fields not updated by write");

	// unmasked lane 2 keeps its word
	a_lane_keep: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
		(wrRoute && !laneWriteMask[2]) |=> $stable(routeReg[2]))
		else $error("unselected lane changed on write");

	// masked lane takes the write
	a_lane_update: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
		(wrRoute && laneWriteMask[3]) |=> routeReg[3] == $past(regWrData)
			&& txLaneIndexPick[3] == $past(regWrData[1:0]))
		else $error("selected lane not updated");

	// lane reset words
	a_lane_reset: assert property (@(posedge clk) // RULE16
		$past(sys_rst) |-> routeReg[0] == 16'h3020 && routeReg[1] == 16'h3121
			&& routeReg[3] == 16'h3323 && rxLaneSourcePick[1] == 2'h2)
		else $error("lane routing reset word wrong");

	// readback of a written lane word two cycles later
	a_route_readback: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
		s_wr_route_then_rd |=> regRdValid && regRdData == $past(regWrData, 2))
		else $error("lane word readback mismatch");

	// unmapped read answers zero one cycle later
	a_unmapped_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
		(regRdEn && !hitMarker && !hitFifo && !hitRoute) |=>
			regRdValid && regRdData == 16'h0000)
		else $error("unmapped read not zero");

	// marker fields take the written value
	a_marker_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
		wrMarker |=> rxMarkerSelect == $past(regWrData[14:12])
			&& markerDetectOn == $past(regWrData[11]))
		else $error("marker fields not updated by write");

	// gated detect is off right after reset
	a_detect_reset: assert property (@(posedge clk) // RULE2
		$past(sys_rst) |-> !markerDetectActive)
		else $error("marker detect active after reset");

	// sync code and its enable take the written value
	a_sync_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
		wrFifo |=> customSyncCodeOn == $past(regWrData[10])
			&& customSyncCode == $past(regWrData[9:0]))
		else $error("sync code fields not updated by write");

	// empty mask route write leaves every lane alone
	a_mask_empty: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
		(wrRoute && laneWriteMask == 4'h0) |=> $stable(routeReg[0]) && $stable(routeReg[1])
			&& $stable(routeReg[2]) && $stable(routeReg[3]))
		else $error("route write with empty mask changed a lane");

	// rx rate and tolerance comp of a selected lane follow the write
	a_rx_rate_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
		(wrRoute && laneWriteMask[0]) |=> rxLaneRateDivider[0] == $past(regWrData[15:14])
			&& rxLaneToleranceCompOn[0] == $past(regWrData[13]))
		else $error("rx rate fields not updated");

	// rx source and lane pick of a selected lane follow the write
	a_rx_pick_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
		(wrRoute && laneWriteMask[1]) |=> rxLaneSourcePick[1] == $past(regWrData[12:11])
			&& rxLaneIndexPick[1] == $past(regWrData[9:8]))
		else $error("rx pick fields not updated");

	// tx rate, tolerance comp and source of a selected lane follow the write
	a_tx_route_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
		(wrRoute && laneWriteMask[2]) |=> txLaneRateDivider[2] == $past(regWrData[7:6])
			&& txLaneToleranceCompOn[2] == $past(regWrData[5])
			&& txLaneSourcePick[2] == $past(regWrData[4:3]))
		else $error("tx route fields not updated");

	// lane 0 outside the mask keeps its word
	a_lane_keep_low: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
		(wrRoute && !laneWriteMask[0]) |=> $stable(routeReg[0]))
		else $error("unselected lane 0 changed on write");

	// marker and fifo words hold when not written
	a_word_hold: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
		!$past(sys_rst) && !wrMarker && !wrFifo |=> $stable(markerReg) && $stable(fifoReg))
		else $error("register word changed without a write");

	// read answer strobe lasts one cycle per request
	a_rd_pulse: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
		!$past(sys_rst) |-> regRdValid == $past(regRdEn))
		else $error("read answer strobe wrong");

	// read beside a write returns the old word
	a_rd_old_word: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
		(regRdEn && wrFifo) |=> regRdData == $past(fifoReg))
		else $error("read beside a write did not return the old word");

endmodule

// >>> tb/test_lane_route_marker_fifo_config.sv
// self-checking bench for the lane route, marker and fifo config registers
`timescale 1ns/100ps

module test_lane_route_marker_fifo_config
	import lrmfc_pkg::*;
;
	// ==========================================================
	// stimulus and observed signals
	logic              clk, sys_rst, regWrEn, regRdEn, rxBitwiseMuxMode, regRdValid;
	logic [4:0]        regAddr;
	lrmfc_word_t       regWrData, regRdData, mk, ff; // mk, ff: expected words
	logic [3:0]        laneWriteMask, rxTc, txTc;
	logic [2:0]        rxMarkerSelect, slowTxBufferDepth;
	logic              markerDetectOn, markerDetectActive, customSyncCodeOn;
	logic [1:0]        slowTxBufferLevel;
	logic [9:0]        customSyncCode;
	logic [3:0][1:0]   rxDiv, rxSrc, rxIdx, txDiv, txSrc, txIdx;
	int                n_errors, check_count;
	lrmfc_word_t       lane [0:3];   // expected per lane routing words

	lrmfc_config_regs dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .regRdValid(regRdValid), .laneWriteMask(laneWriteMask),
		.rxBitwiseMuxMode(rxBitwiseMuxMode), .rxMarkerSelect(rxMarkerSelect),
		.markerDetectOn(markerDetectOn), .markerDetectActive(markerDetectActive),
		.slowTxBufferDepth(slowTxBufferDepth), .slowTxBufferLevel(slowTxBufferLevel),
		.customSyncCodeOn(customSyncCodeOn), .customSyncCode(customSyncCode),
		.rxLaneRateDivider(rxDiv), .rxLaneToleranceCompOn(rxTc), .rxLaneSourcePick(rxSrc),
		.rxLaneIndexPick(rxIdx), .txLaneRateDivider(txDiv), .txLaneToleranceCompOn(txTc),
		.txLaneSourcePick(txSrc), .txLaneIndexPick(txIdx));

	// ==========================================================
	// shared tasks
	task automatic check(input lrmfc_word_t seen, input lrmfc_word_t exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one write pulse, taken at the second edge
	task automatic wr(input logic [4:0] a, input lrmfc_word_t d, input logic [3:0] m);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		laneWriteMask <= m;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask
	// one read pulse, answer judged one cycle later
	task automatic rd(input logic [4:0] a, input logic [3:0] m, input lrmfc_word_t exp);
		@(posedge clk);
		regAddr <= a;
		laneWriteMask <= m;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1;
		check(regRdValid, 1'b1);
		check(regRdData, exp);
	endtask
	// compare every field output except markerDetectActive and read every word back
	task automatic chk_out();
		check(rxMarkerSelect, mk[14:12]);
		check(markerDetectOn, mk[11]);
		check(slowTxBufferDepth, ff[15:13]);
		check(slowTxBufferLevel, ff[12:11]);
		check(customSyncCodeOn, ff[10]);
		check(customSyncCode, ff[9:0]);
		for (int i = 0; i < 4; i++) begin
			check(rxDiv[i], lane[i][15:14]);
			check(rxTc[i], lane[i][13]);
			check(rxSrc[i], lane[i][12:11]);
			check(rxIdx[i], lane[i][9:8]);
			check(txDiv[i], lane[i][7:6]);
			check(txTc[i], lane[i][5]);
			check(txSrc[i], lane[i][4:3]);
			check(txIdx[i], lane[i][1:0]);
			rd(LRMFC_ADDR_ROUTE, 4'(1 << i), lane[i]);
		end
		rd(LRMFC_ADDR_MARKER, 4'h0, mk);
		rd(LRMFC_ADDR_FIFO, 4'h0, ff);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		mk = 16'h0cc8;
		ff = 16'h02bc;
		for (int i = 0; i < 4; i++) lane[i] = 16'h3020 + 16'(16'h0101 * i);
		#1;
		check(markerDetectActive, 1'b0);
		chk_out();
		$display("test reset values done");
	endtask
	task automatic t_fifo();
		wr(LRMFC_ADDR_FIFO, 16'hb6a5, 4'h0);
		ff = 16'hb6a5;
		#1;
		chk_out();
		wr(LRMFC_ADDR_FIFO, 16'h4b5a, 4'h0);
		ff = 16'h4b5a;
		#1;
		chk_out();
		$display("test fifo register done");
	endtask
	task automatic t_marker();
		wr(LRMFC_ADDR_MARKER, 16'h3800, 4'h0);
		@(posedge clk);
		#1;
		check(markerDetectActive, 1'b0);
		@(posedge clk);
		rxBitwiseMuxMode <= 1'b1;
		@(posedge clk);
		#1;
		check(markerDetectActive, 1'b1);
		wr(LRMFC_ADDR_MARKER, 16'h5000, 4'h0);
		@(posedge clk);
		#1;
		check(markerDetectActive, 1'b0);
		mk = 16'h5000;
		chk_out();
		$display("test marker register done");
	endtask
	task automatic t_route();
		lrmfc_word_t dat [5] = '{16'hffff, 16'h4c8c, 16'hb354, 16'h1f27, 16'h6a1d};
		logic [3:0]  msk [5] = '{4'h0, 4'h5, 4'ha, 4'h8, 4'hf};
		for (int k = 0; k < 5; k++) begin
			wr(LRMFC_ADDR_ROUTE, dat[k], msk[k]);
			// masked lanes only
			for (int i = 0; i < 4; i++) if (msk[k][i]) lane[i] = dat[k];
			#1;
			chk_out();
		end
		$display("test lane routing done");
	endtask
	task automatic t_b2b();
		// route write and its read back to back
		@(posedge clk);
		regAddr <= LRMFC_ADDR_ROUTE;
		regWrData <= 16'h2d4b;
		laneWriteMask <= 4'h1;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
		regRdEn <= 1'b1;
		lane[0] = 16'h2d4b;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1;
		check(regRdValid, 1'b1);
		check(regRdData, lane[0]);
		// read and write of the fifo word in one cycle returns the old word
		@(posedge clk);
		regAddr <= LRMFC_ADDR_FIFO;
		regWrData <= 16'h1c3e;
		regWrEn <= 1'b1;
		regRdEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
		regRdEn <= 1'b0;
		#1;
		check(regRdData, ff);
		ff = 16'h1c3e;
		// read lane: lane 0 on empty mask, else lowest set bit
		rd(LRMFC_ADDR_ROUTE, 4'h0, lane[0]);
		rd(LRMFC_ADDR_ROUTE, 4'hc, lane[2]);
		chk_out();
		$display("test back to back access done");
	endtask
	task automatic t_unmapped();
		wr(5'h1a, 16'hffff, 4'hf);
		wr(5'h00, 16'hffff, 4'hf);
		rd(5'h1a, 4'h0, 16'h0000);
		rd(5'h1f, 4'h0, 16'h0000);
		chk_out();
		$display("test unmapped addresses done");
	endtask

	// ==========================================================
	// verdict, clock, watchdog and main sequence
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		results();
	end
	initial begin
		sys_rst = 1'b1;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 5'h00;
		regWrData = 16'h0000;
		laneWriteMask = 4'h0;
		rxBitwiseMuxMode = 1'b0;
		t_reset();
		t_fifo();
		t_marker();
		t_route();
		t_b2b();
		t_unmapped();
		t_reset();
		results();
	end
endmodule
